// ---- rtl/pee_defines.svh ----
// Constants for the parallel EEPROM host controller: offsets, fields, timing.
`ifndef PEE_DEFINES_SVH
`define PEE_DEFINES_SVH
// ----------------------------------------------------------------------
// Register offsets (byte addresses on the AHB-Lite bus)
// ----------------------------------------------------------------------
`define PEE_OFS_CTRL    12'h000
`define PEE_OFS_ADDR    12'h004
`define PEE_OFS_COUNT   12'h008
`define PEE_OFS_STATUS  12'h00C
`define PEE_OFS_BUF     12'h100
// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define PEE_CTRL_GO     0
`define PEE_CTRL_OP_LO  1
`define PEE_CTRL_OP_HI  3
`define PEE_CTRL_POLL   4
`define PEE_CTRL_PROT   5
`define PEE_PAGE_BYTES  64
// ----------------------------------------------------------------------
// Timing, printed figures and the clock rate
// ----------------------------------------------------------------------
`define PEE_CLK_NS      20
`define PEE_T_WEL_NS    150
`define PEE_T_BLC_MIN_NS 200
`define PEE_T_BLC_MAX_NS 2000
`define PEE_T_ACC_NS    350
`define PEE_T_POLL_NS   200
`define PEE_T_BUSY_NS   100
`define PEE_T_HVSU_NS   1000
`define PEE_T_CLEAR_MS  10
`define PEE_T_WRITE_MS  10
`endif

// ---- rtl/pee_pkg.sv ----
// Types shared by the parallel EEPROM host controller.
package pee_pkg;
  typedef enum logic [2:0] {
    PEE_OP_READ, PEE_OP_WRITE, PEE_OP_CLEAR, PEE_OP_PSET, PEE_OP_PRESET
  } pee_op_t;
  typedef enum logic [3:0] {
    S_IDLE, S_RD, S_LOAD_SU, S_WE_LO, S_WE_HI, S_BUSY_GAP, S_RDY,
    S_POLL_GAP, S_POLL, S_POLL_HI, S_HV_SU, S_HV_LO, S_HV_HO, S_DONE
  } pee_state_t;
  // Pin bundle driven toward the memory device.
  typedef struct packed {
    logic [12:0] addr;
    logic [7:0]  dq;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        hv_en;
  } pee_pins_t;
endpackage

// ---- rtl/pee_host.sv ----
// Host controller driving a byte-wide EEPROM, commanded over AHB-Lite.
//
// Operation
// [R01] Device writes only while chip select and write strobe are both low.
// [R02] Device ignores write-strobe pulses shorter than 20 ns.
// [R03] One page load carries 1 to 64 bytes.
// [R04] Successive byte-load strobes are spaced 0.2 to 2 microseconds apart.
// [R05] Polled data reflects the write within 200 ns of the last byte.
// [R06] Ready output goes busy within 50 or 100 ns of strobe rise.
// [R07] Internal write signalled on ready output finishes within 1 or 10 ms.
// [R08] Ready output exists only on some variants; others leave it open.
// [R09] Verify uses a normal read: select and output enable low, strobe high.
// [R10] With chip select high the device stands by, data lines floating.
// [R11] No write starts while strobe is high or output enable low.
// [R12] Chip clear: select low, strobe low, output enable at high voltage.
// [R13] Chip clear holds the write strobe low for at least 10 ms.
// [R14] Protection commands use page-write byte-load timing.
// [R15] Unlock commands and protected data form one continuous load.
// [R16] Sequence timing runs from the later fall to the earlier rise.
// [R17] Ready output low during internal write, released high at its end.
// [R18] Protect sequence locks writes; later writes need the sequence first.
// [R19] Another command sequence removes protection.
// [R20] Erase leaves every affected bit at one.
// [R21] Host starts no new write before the prior one finishes.
// [R22] Bytes of one page share the upper address bits.
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "pee_defines.svh"
module pee_host #(
  parameter int          CLEAR_CYC   = `PEE_T_CLEAR_MS * 1000000 / `PEE_CLK_NS,
  parameter int          TIMEOUT_CYC = `PEE_T_WRITE_MS * 1000000 / `PEE_CLK_NS,
  parameter logic [12:0] CMD_ADDR_A  = 13'h0AAA,
  parameter logic [12:0] CMD_ADDR_B  = 13'h0555,
  parameter logic [7:0]  CMD_KEY_A   = 8'h5A,
  parameter logic [7:0]  CMD_KEY_B   = 8'hA5,
  parameter logic [7:0]  CMD_LOCK    = 8'h3C,
  parameter logic [7:0]  CMD_UNLOCK  = 8'hC3
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic [31:0]           hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  output pee_pkg::pee_pins_t    pins,
  input  wire logic [7:0]       dq_in,
  input  wire logic             ready_in
);
  // ----------------------------------------------------------------------
  // Derived cycle counts
  // ----------------------------------------------------------------------
  localparam int NS = `PEE_CLK_NS;
  localparam int WEL_CYC  = (`PEE_T_WEL_NS + NS - 1) / NS;
  localparam int BLC_CYC  = (`PEE_T_BLC_MIN_NS + NS - 1) / NS;
  localparam int BLCX_CYC = `PEE_T_BLC_MAX_NS / NS;
  localparam int ACC_CYC  = (`PEE_T_ACC_NS + NS - 1) / NS;
  localparam int POLL_CYC = (`PEE_T_POLL_NS + NS - 1) / NS;
  localparam int BUSY_CYC = (`PEE_T_BUSY_NS + NS - 1) / NS;
  localparam int HVSU_CYC = (`PEE_T_HVSU_NS + NS - 1) / NS;

  pee_pkg::pee_state_t state_reg;
  pee_pkg::pee_op_t    op_reg;
  logic [31:0] ctrl_reg;
  logic [12:0] base_reg;
  logic [5:0]  count_reg;
  logic [7:0]  rdata_reg;
  logic        done_reg;
  logic        tmo_reg;
  logic [19:0] cnt_reg;
  logic [19:0] tmo_cnt_reg;
  logic [6:0]  idx_reg;
  logic [6:0]  total_reg;
  logic [2:0]  pre_reg;
  logic        poll_reg;
  logic [7:0]  last_reg;
  logic [7:0]  buf_mem [`PEE_PAGE_BYTES];
  logic        aw_reg;
  logic [11:0] aaddr_reg;
  logic [12:0] nx_addr;
  logic [7:0]  nx_data;
  logic [6:0]  nx_off;
  logic        go;

  // ----------------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------------
  // Address phase is registered; reads are answered from a flop next cycle.
  always_ff @(posedge clock) begin
    if (srst) begin
      aw_reg    <= 1'b0;
      aaddr_reg <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      aw_reg    <= hsel && hready && htrans[1] && hwrite;
      aaddr_reg <= haddr[11:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
        unique case (haddr[11:0])
          `PEE_OFS_CTRL:   hrdata <= ctrl_reg;
          `PEE_OFS_ADDR:   hrdata <= {19'h0_0000, base_reg};
          `PEE_OFS_COUNT:  hrdata <= {26'h000_0000, count_reg};
          `PEE_OFS_STATUS: hrdata <= {16'h0000, rdata_reg, 5'h00, tmo_reg, done_reg,
                                      state_reg != pee_pkg::S_IDLE};
          default:         hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Go pulse: only taken while idle, so a write never overlaps one in progress.
  assign go = aw_reg && aaddr_reg == `PEE_OFS_CTRL && hwdata[`PEE_CTRL_GO] &&
              state_reg == pee_pkg::S_IDLE; // R21

  // Software-written registers: address and count steer the sequencer, control is kept for readback.
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_reg  <= 32'h0000_0000;
      base_reg  <= 13'h0000;
      count_reg <= 6'h00;
    end else if (aw_reg && state_reg == pee_pkg::S_IDLE) begin
      if (aaddr_reg == `PEE_OFS_CTRL) ctrl_reg <= {26'h000_0000, hwdata[5:1], 1'b0};
      if (aaddr_reg == `PEE_OFS_ADDR) base_reg <= hwdata[12:0];
      if (aaddr_reg == `PEE_OFS_COUNT) count_reg <= hwdata[5:0]; // R03
    end
  end

  // Page buffer, one byte per word slot above the buffer offset.
  always_ff @(posedge clock) begin
    if (aw_reg && aaddr_reg[11:8] == 4'h1 && state_reg == pee_pkg::S_IDLE) begin
      buf_mem[aaddr_reg[7:2]] <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Byte source: command prefix, then page data
  // ----------------------------------------------------------------------
  // Commands form the front of the same load as the data that follows.
  always_comb begin
    nx_off  = idx_reg - {4'h0, pre_reg};
    nx_addr = {base_reg[12:6], base_reg[5:0] + nx_off[5:0]}; // R22
    nx_data = buf_mem[nx_off[5:0]];
    if (idx_reg < {4'h0, pre_reg}) begin // R15
      nx_addr = idx_reg[0] ? CMD_ADDR_B : CMD_ADDR_A;
      nx_data = idx_reg[0] ? CMD_KEY_B : CMD_KEY_A;
      if (idx_reg == 7'd2) nx_data = (op_reg == pee_pkg::PEE_OP_PRESET) ? 8'h80 : CMD_LOCK;
      if (idx_reg == 7'd5) nx_data = CMD_UNLOCK; // R19
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // One process walks every operation; a shared counter paces each timed step, the watchdog counter bounds the ready and poll waits.
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= pee_pkg::S_IDLE;
      op_reg    <= pee_pkg::PEE_OP_READ;
      cnt_reg   <= 20'h0_0000;
      idx_reg   <= 7'h00;
      total_reg <= 7'h00;
      pre_reg   <= 3'h0;
      poll_reg  <= 1'b0;
      last_reg  <= 8'h00;
      rdata_reg <= 8'h00;
      done_reg  <= 1'b0;
      tmo_reg   <= 1'b0;
      pins      <= '{addr: 13'h0000, dq: 8'h00, dq_oe: 1'b0, ce_n: 1'b1,
                     oe_n: 1'b1, we_n: 1'b1, hv_en: 1'b0}; // R10
    end else begin
      cnt_reg <= cnt_reg + 20'h0_0001;
      unique case (state_reg)
        pee_pkg::S_IDLE: if (go) begin
          op_reg   <= pee_pkg::pee_op_t'(hwdata[`PEE_CTRL_OP_HI:`PEE_CTRL_OP_LO]);
          poll_reg <= hwdata[`PEE_CTRL_POLL]; // R08
          done_reg <= 1'b0;
          tmo_reg  <= 1'b0;
          idx_reg  <= 7'h00;
          cnt_reg  <= 20'h0_0000;
          pins.addr <= base_reg;
          pins.ce_n <= 1'b0;
          unique case (pee_pkg::pee_op_t'(hwdata[`PEE_CTRL_OP_HI:`PEE_CTRL_OP_LO]))
            pee_pkg::PEE_OP_READ: begin
              pins.oe_n <= 1'b0; // R09
              state_reg <= pee_pkg::S_RD;
            end
            pee_pkg::PEE_OP_CLEAR: begin
              pins.hv_en <= 1'b1; // R12 R20
              state_reg  <= pee_pkg::S_HV_SU;
            end
            pee_pkg::PEE_OP_WRITE: begin
              pre_reg   <= hwdata[`PEE_CTRL_PROT] ? 3'd3 : 3'd0; // R18
              total_reg <= (hwdata[`PEE_CTRL_PROT] ? 7'd4 : 7'd1) + {1'b0, count_reg};
              state_reg <= pee_pkg::S_LOAD_SU;
            end
            pee_pkg::PEE_OP_PSET: begin
              pre_reg   <= 3'd3; // R14
              total_reg <= 7'd3;
              state_reg <= pee_pkg::S_LOAD_SU;
            end
            default: begin
              pre_reg   <= 3'd6; // R19
              total_reg <= 7'd6;
              state_reg <= pee_pkg::S_LOAD_SU;
            end
          endcase
        end
        pee_pkg::S_RD: if (cnt_reg == 20'(ACC_CYC)) begin
          rdata_reg <= dq_in;
          pins.oe_n <= 1'b1;
          pins.ce_n <= 1'b1;
          state_reg <= pee_pkg::S_DONE;
        end
        pee_pkg::S_LOAD_SU: begin
          pins.addr  <= nx_addr;
          pins.dq    <= nx_data;
          pins.dq_oe <= 1'b1;
          cnt_reg    <= 20'h0_0000;
          state_reg  <= pee_pkg::S_WE_LO;
        end
        pee_pkg::S_WE_LO: begin
          pins.we_n <= 1'b0; // R01
          last_reg  <= pins.dq;
          if (cnt_reg == 20'(WEL_CYC)) begin // R02
            pins.we_n <= 1'b1;
            idx_reg   <= idx_reg + 7'h01;
            cnt_reg   <= 20'h0_0000;
            state_reg <= pee_pkg::S_WE_HI;
          end
        end
        pee_pkg::S_WE_HI: begin
          if (idx_reg == total_reg) begin
            pins.dq_oe  <= 1'b0;
            pins.ce_n   <= 1'b1; // R16
            cnt_reg     <= 20'h0_0000;
            state_reg   <= poll_reg ? pee_pkg::S_POLL_GAP : pee_pkg::S_BUSY_GAP;
          end else if (cnt_reg == 20'h0_0001) begin
            pins.addr <= nx_addr;
            pins.dq   <= nx_data;
          end else if (cnt_reg == 20'(BLC_CYC - 1)) begin // R04
            cnt_reg   <= 20'h0_0000;
            state_reg <= pee_pkg::S_WE_LO;
          end
        end
        pee_pkg::S_BUSY_GAP: if (cnt_reg == 20'(BUSY_CYC)) state_reg <= pee_pkg::S_RDY; // R06
        pee_pkg::S_RDY: if (ready_in) begin // R17
          state_reg <= pee_pkg::S_DONE;
        end else if (tmo_cnt_reg == 20'(TIMEOUT_CYC)) begin // R07
          tmo_reg   <= 1'b1;
          state_reg <= pee_pkg::S_DONE;
        end
        pee_pkg::S_POLL_GAP: if (cnt_reg == 20'(POLL_CYC)) begin // R05
          pins.ce_n <= 1'b0;
          pins.oe_n <= 1'b0;
          cnt_reg   <= 20'h0_0000;
          state_reg <= pee_pkg::S_POLL;
        end
        pee_pkg::S_POLL: if (cnt_reg == 20'(ACC_CYC)) begin
          pins.ce_n <= 1'b1;
          pins.oe_n <= 1'b1;
          rdata_reg <= dq_in;
          cnt_reg   <= 20'h0_0000;
          if (dq_in[7] == last_reg[7]) state_reg <= pee_pkg::S_DONE;
          else if (tmo_cnt_reg >= 20'(TIMEOUT_CYC)) begin
            tmo_reg   <= 1'b1;
            state_reg <= pee_pkg::S_DONE;
          end else state_reg <= pee_pkg::S_POLL_GAP;
        end
        pee_pkg::S_HV_SU: if (cnt_reg == 20'(HVSU_CYC)) begin
          pins.we_n <= 1'b0;
          cnt_reg   <= 20'h0_0000;
          state_reg <= pee_pkg::S_HV_LO;
        end
        pee_pkg::S_HV_LO: if (cnt_reg == 20'(CLEAR_CYC)) begin // R13
          pins.we_n <= 1'b1;
          cnt_reg   <= 20'h0_0000;
          state_reg <= pee_pkg::S_HV_HO;
        end
        pee_pkg::S_HV_HO: if (cnt_reg == 20'(HVSU_CYC)) begin
          pins.hv_en <= 1'b0;
          pins.ce_n  <= 1'b1;
          state_reg  <= pee_pkg::S_DONE;
        end
        default: begin
          done_reg  <= 1'b1;
          state_reg <= pee_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Completion watchdog: held at zero through the load, then counts the internal write.
  always_ff @(posedge clock) begin
    if (srst) tmo_cnt_reg <= 20'h0_0000;
    else if (state_reg == pee_pkg::S_LOAD_SU || state_reg == pee_pkg::S_WE_LO ||
             state_reg == pee_pkg::S_WE_HI) tmo_cnt_reg <= 20'h0_0000;
    else if (tmo_cnt_reg != 20'hF_FFFF) tmo_cnt_reg <= tmo_cnt_reg + 20'h0_0001;
  end

  // ----------------------------------------------------------------------
  // Checks on the pins driven toward the device and on the sequencer's ready wait
  // ----------------------------------------------------------------------
  logic [19:0] hi_cnt;
  logic [19:0] lo_cnt;
  // Helper counters measure how long the strobe stays high and low.
  always_ff @(posedge clock) begin
    if (srst || pins.we_n) lo_cnt <= 20'h0_0000;
    else lo_cnt <= lo_cnt + 20'h0_0001;
    if (srst || !pins.we_n) hi_cnt <= 20'h0_0000;
    else hi_cnt <= hi_cnt + 20'h0_0001;
  end

  sequence strobe_fall_s;
    $fell(pins.we_n) && !pins.hv_en;
  endsequence
  sequence strobe_low_s;
    !pins.we_n [*8];
  endsequence

  we_pulse_width_a: assert property (@(posedge clock) disable iff (srst) // R02
    strobe_fall_s |-> strobe_low_s) else $error("Write strobe pulse too short.");
  ce_with_we_a: assert property (@(posedge clock) disable iff (srst) // R01
    !pins.we_n |-> !pins.ce_n) else $error("Strobe low without chip select.");
  oe_high_write_a: assert property (@(posedge clock) disable iff (srst) // R11
    (!pins.we_n && !pins.hv_en) |-> pins.oe_n) else $error("Output enable low in write.");
  read_no_drive_a: assert property (@(posedge clock) disable iff (srst) // R09
    !pins.oe_n |-> (!pins.dq_oe && pins.we_n)) else $error("Data driven during read.");
  load_spacing_a: assert property (@(posedge clock) disable iff (srst) // R04
    (strobe_fall_s and (idx_reg != 7'h00)) |->
    hi_cnt >= 20'd10 && hi_cnt <= 20'd100)
    else $error("Byte load spacing out of range.");
  clear_level_a: assert property (@(posedge clock) disable iff (srst) // R12
    state_reg == pee_pkg::S_HV_LO |-> pins.hv_en && !pins.ce_n && !pins.we_n)
    else $error("Chip clear pins wrong.");
  clear_length_a: assert property (@(posedge clock) disable iff (srst) // R13
    $rose(pins.we_n) && pins.hv_en |-> lo_cnt >= 20'(CLEAR_CYC))
    else $error("Chip clear strobe too short.");
  page_upper_a: assert property (@(posedge clock) disable iff (srst) // R22
    (!pins.we_n && op_reg == pee_pkg::PEE_OP_WRITE && idx_reg >= {4'h0, pre_reg}) |->
    pins.addr[12:6] == base_reg[12:6]) else $error("Page address left its page.");
  ready_wait_a: assert property (@(posedge clock) disable iff (srst) // R17
    (state_reg == pee_pkg::S_RDY && ready_in) |=> state_reg == pee_pkg::S_DONE ##1
    state_reg == pee_pkg::S_IDLE && done_reg) else $error("Ready not honoured.");
endmodule // pee_host
`default_nettype wire

// ---- bench/pee_mem_model.sv ----
// Behavioural model of the byte-wide EEPROM that faces the host controller.
`timescale 1ns/100ps
`default_nettype none
module pee_mem_model #(
  parameter int          WR_CYC  = 300,
  parameter int          CLR_MIN = 200,
  parameter logic [12:0] CA      = 13'h0AAA,
  parameter logic [12:0] CB      = 13'h0555,
  parameter logic [7:0]  KA      = 8'h5A,
  parameter logic [7:0]  KB      = 8'hA5,
  parameter logic [7:0]  LOCK    = 8'h3C,
  parameter logic [7:0]  UNLOCK  = 8'hC3
) (
  input  wire pee_pkg::pee_pins_t pins,
  input  wire logic               clock,
  input  wire logic               stuck,
  output logic [7:0]              dq_in,
  output logic                    ready_in,
  output var int                  viol
);
  logic [7:0]  mem [8192];
  logic [12:0] la [70];
  logic [7:0]  ld [70];
  logic [7:0]  last_q;
  logic [7:0]  last_w;
  logic        prot = 1'b0;
  logic        was_lo = 1'b0;
  int          n = 0;
  int          lo = 0;
  int          gap = 0;
  int          prog = 0;
  int          clr = 0;
  // A byte strobe needs select and strobe low, output enable high, no erase level.
  wire logic wr_lo = !pins.ce_n && !pins.we_n && pins.oe_n && !pins.hv_en;
  wire logic rd_en = !pins.ce_n && !pins.oe_n && pins.we_n && !pins.hv_en;
  wire logic busy = (n > 0) || (prog > 0);

  // The array starts with each byte equal to its low address bits.
  initial begin
    viol = 0;
    for (int i = 0; i < 8192; i++) mem[i] = 8'(i);
  end

  // Ready pin is open drain with a pull-up, so it reads high unless busy or stuck.
  assign ready_in = !(busy || stuck);

  // Data bus: read data, polled complement, host data, or drift when undriven.
  always_comb begin
    if (rd_en) dq_in = busy ? {~last_w[7], last_w[6:0]} : mem[pins.addr];
    else if (pins.dq_oe) dq_in = pins.dq;
    else dq_in = ~last_q;
  end

  function automatic logic hit(int i, logic [12:0] a, logic [7:0] d);
    return la[i] === a && ld[i] === d;
  endfunction

  // Command bytes sit at fixed addresses outside the page being loaded.
  function automatic logic is_cmd(logic [12:0] a);
    return a === CA || a === CB;
  endfunction

  // Byte loads, load window, command decoding, programming timer, chip clear.
  always @(posedge clock) begin
    int s;
    logic ok;
    s = 0;
    ok = !prot;
    last_q <= dq_in;
    was_lo <= wr_lo;
    lo <= wr_lo ? lo + 1 : 0;
    if (prog > 0) prog <= prog - 1;
    if (rd_en && pins.dq_oe) viol++;
    if (wr_lo && !was_lo && ((n > 0 && gap < 10) || prog > 0)) viol++;
    if (was_lo && !wr_lo && lo >= 2) begin
      if (lo < 8) viol++;
      if (n > 0 && !is_cmd(pins.addr) && !is_cmd(la[n - 1])
          && pins.addr[12:6] !== la[n - 1][12:6]) viol++;
      la[n] <= pins.addr;
      ld[n] <= pins.dq;
      last_w <= pins.dq;
      n <= n + 1;
      gap <= 1;
    end else if (n > 0 && gap > 100) begin
      if (n >= 3 && hit(0, CA, KA) && hit(1, CB, KB) && hit(2, CA, LOCK)) begin
        prot <= 1'b1;
        s = 3;
        ok = 1'b1;
      end else if (n >= 6 && hit(0, CA, KA) && hit(1, CB, KB) && hit(2, CA, 8'h80)
                   && hit(3, CB, KB) && hit(4, CA, KA) && hit(5, CB, UNLOCK)) begin
        prot <= 1'b0;
        s = 6;
        ok = 1'b1;
      end
      for (int i = s; i < n; i++) if (ok) mem[la[i]] <= ld[i];
      n <= 0;
      prog <= WR_CYC;
    end else gap <= gap + 1;
    if (pins.hv_en && !pins.ce_n && !pins.we_n) clr <= clr + 1;
    else if (clr > 0) begin
      if (clr < CLR_MIN) viol++;
      else for (int i = 0; i < 8192; i++) mem[i] <= 8'hFF;
      clr <= 0;
    end
  end
endmodule // pee_mem_model
`default_nettype wire

// ---- bench/pee_host_tb.sv ----
// Self-checking bench: register tasks drive the controller against the device model.
`timescale 1ns/100ps
`default_nettype none
`include "pee_defines.svh"
module pee_host_tb;
  logic               clock = 1'b0;
  logic               srst = 1'b1;
  logic               hsel = 1'b0;
  logic               hwrite = 1'b0;
  logic               stuck = 1'b0;
  logic [1:0]         htrans = 2'b00;
  logic [31:0]        haddr = 32'h0000_0000;
  logic [31:0]        hwdata = 32'h0000_0000;
  logic [31:0]        hrdata;
  logic [31:0]        rd;
  logic               hreadyout;
  logic               hresp;
  logic               ready_in;
  logic [7:0]         dq_in;
  pee_pkg::pee_pins_t pins;
  int                 viol;
  int                 n_fail = 0;
  int                 n_checks = 0;
  int                 cyc = 0;

  pee_host #(.CLEAR_CYC(200), .TIMEOUT_CYC(2000)) pee_host_i (
    .clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
    .dq_in(dq_in), .ready_in(ready_in));
  pee_mem_model #(.CLR_MIN(200)) pee_mem_model_i (
    .pins(pins), .clock(clock), .stuck(stuck), .dq_in(dq_in),
    .ready_in(ready_in), .viol(viol));

  // Free-running 50 MHz clock.
  always #10 clock = ~clock;

  // ----------------------------------------------------------------------
  // Bus and checking tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One single word transfer; read data is kept in rd.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    htrans <= 2'b10;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask

  // Start an operation and wait until status shows done and not busy.
  task automatic run(input logic [31:0] ctl);
    xfer(1'b1, `PEE_OFS_CTRL, ctl);
    xfer(1'b0, `PEE_OFS_STATUS, 32'h0000_0000);
    do xfer(1'b0, `PEE_OFS_STATUS, 32'h0000_0000);
    while (rd[1:0] !== 2'b10);
  endtask

  // Load nb bytes counting up from v at address a, then run ctl.
  task automatic load(input logic [12:0] a, input int nb, input logic [7:0] v,
                      input logic [31:0] ctl);
    for (int k = 0; k < nb; k++) xfer(1'b1, `PEE_OFS_BUF + 12'(4 * k), 32'(v + 8'(k)));
    xfer(1'b1, `PEE_OFS_ADDR, 32'(a));
    xfer(1'b1, `PEE_OFS_COUNT, 32'(nb - 1));
    run(ctl);
  endtask

  task automatic peek(input logic [12:0] a);
    load(a, 1, 8'h00, 32'h0000_0001);
  endtask

  task automatic cm(input logic [12:0] a, input logic [7:0] e);
    check("memory byte", 32'(pee_mem_model_i.mem[a]), 32'(e));
  endtask

  // Cuts a hung run short.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    check("idle pins", 32'({pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe, pins.hv_en}),
          32'h0000_001C);
    xfer(1'b0, `PEE_OFS_STATUS, 32'h0000_0000);
    check("status after reset", rd, 32'h0000_0000);
    xfer(1'b0, 12'h0F0, 32'h0000_0000);
    check("unmapped read", rd, 32'h0000_0000);
    // Full page of 64 bytes, then neighbours untouched and a normal read back.
    load(13'h0040, 64, 8'h30, 32'h0000_0003);
    for (int k = 0; k < 64; k++) cm(13'h0040 + 13'(k), 8'h30 + 8'(k));
    cm(13'h003F, 8'h3F);
    cm(13'h0080, 8'h80);
    peek(13'h0045);
    check("read back", 32'(rd[15:8]), 32'h0000_0035);
    // Single byte at the top address, completion found by polling.
    load(13'h1FFF, 1, 8'h81, 32'h0000_0013);
    check("poll timeout flag", 32'(rd[2]), 32'h0000_0000);
    cm(13'h1FFF, 8'h81);
    // Lock, refused plain write, protected write, unlock, plain write.
    load(13'h0100, 1, 8'h11, 32'h0000_0007);
    cm(13'h0100, 8'h00);
    check("locked", 32'(pee_mem_model_i.prot), 32'h0000_0001);
    load(13'h0101, 1, 8'h22, 32'h0000_0003);
    cm(13'h0101, 8'h01);
    load(13'h0101, 1, 8'h33, 32'h0000_0023);
    cm(13'h0101, 8'h33);
    load(13'h0102, 1, 8'h00, 32'h0000_0009);
    check("unlocked", 32'(pee_mem_model_i.prot), 32'h0000_0000);
    load(13'h0102, 1, 8'h44, 32'h0000_0003);
    cm(13'h0102, 8'h44);
    // Chip clear leaves every byte erased.
    run(32'h0000_0005);
    cm(13'h0040, 8'hFF);
    cm(13'h1FFF, 8'hFF);
    peek(13'h0101);
    check("read after clear", 32'(rd[15:8]), 32'h0000_00FF);
    // Device never reports ready: the write ends by timeout.
    stuck <= 1'b1;
    load(13'h0200, 1, 8'h55, 32'h0000_0003);
    check("timeout flag", 32'(rd[2]), 32'h0000_0001);
    stuck <= 1'b0;
    repeat (500) @(posedge clock);
    check("host timing faults", 32'(viol), 32'h0000_0000);
    end_of_test();
  end
endmodule // pee_host_tb
`default_nettype wire
